// [rtl/conv_ctrl.sv]
// Converter channel select, result register and clock control.
// Assumes an external successive-approximation core returning a sample
// for the routed channel; sample data come in as bytes, reference codes are byte constants.
//
// How it works
// (R1) Channel codes 0 to 7 route external inputs 0 to 7 in order to the converter.
// (R2) Code 11101 routes the high reference and 11110 the low reference.
// (R3) Channel code all ones powers the converter off.
// (R4) Software waits one conversion after leaving power-off before trusting a result.
// (R5) Reserved channel codes give an undefined result.
// (R6) One 8-bit result register is loaded every time a conversion completes.
// (R7) The 3-bit prescaler divides by 1, 2, 4 or 8 for codes 0 to 3, and by 16 when its top bit is set.
// (R8) Source select 1 takes the bus clock, 0 the oscillator clock.
// (R9) Reset selects the oscillator clock as source.
// (R10) Software picks source and divider to give about 1 MHz.
// (R11) A status and control write starts a conversion lasting 16 or 17 converter clocks.
// (R12) Continuous mode overwrites results; with interrupts off the flag sets once then clears on write or result read.
// (R13) With interrupts enabled each conversion end requests an interrupt, cleared likewise.
// (R14) Stop mode aborts any conversion; none restarts after it ends until a status and control write.
// (R15) Power-off code completes no conversion and sets neither flag nor request.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int NUM_CH = 8
)(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [2:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    input  wire logic              stop_mode,
    input  wire logic              oscillator_reference_clock,
    input  wire logic [NUM_CH*8-1:0] analog_input_channels,
    output logic [NUM_CH-1:0]      channel_route,
    output logic                   route_reference_high,
    output logic                   route_reference_low,
    output logic                   converter_power_on,
    output logic                   converter_busy,
    output logic                   conversion_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SYNC = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;

    conv_state_t   state_ff, nxt_state;
    logic [4:0]    channel_select_field_ff, nxt_channel;
    logic          continuous_ff, nxt_continuous;
    logic          irq_en_ff, nxt_irq_en;
    logic          complete_ff, nxt_complete;
    logic          first_done_ff, nxt_first_done;
    logic [7:0]    result_ff, nxt_result;
    logic [2:0]    prescale_ff, nxt_prescale;
    logic          source_ff, nxt_source;
    logic [4:0]    cycle_ff, nxt_cycle;
    logic [7:0]    rdata_ff, nxt_rdata;
    logic [NUM_CH-1:0] route_ff, nxt_route;
    logic          ref_hi_ff, nxt_ref_hi;
    logic          ref_lo_ff, nxt_ref_lo;
    logic          power_ff, nxt_power;
    logic          irq_ff, nxt_irq;
    logic          busy_ff, nxt_busy;

    logic          wr_ctrl;
    logic          rd_result;
    logic          powered;
    logic          conv_tick;
    logic          done;
    logic [7:0]    sample;

    assign wr_ctrl   = reg_wr && reg_addr == ADDR_STATUS_CONTROL;
    assign rd_result = reg_rd && reg_addr == ADDR_RESULT;
    assign powered   = channel_select_field_ff != CHAN_POWER_OFF;  // R3

    // ------------------------------------------------------------
    // Converter clock
    // ------------------------------------------------------------
    conv_clock_gen u_clk (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .run        (state_ff != ST_IDLE),
        .source_sel (source_ff),
        .prescale   (prescale_ff),
        .osc_ref    (oscillator_reference_clock),
        .conv_tick  (conv_tick)
    );

    // ------------------------------------------------------------
    // Channel routing
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_route
            assign nxt_route[g] = channel_select_field_ff == 5'(g);  // R1
        end
    endgenerate

    always_comb begin
        nxt_ref_hi = channel_select_field_ff == CHAN_REF_HIGH;  // R2
        nxt_ref_lo = channel_select_field_ff == CHAN_REF_LOW;   // R2
        nxt_power  = powered && !stop_mode;                     // R3
        // Reserved codes return whatever lies on channel zero: undefined
        if (channel_select_field_ff <= CHAN_LAST_EXT) begin
            sample = analog_input_channels[channel_select_field_ff[2:0]*8 +: 8];
        end else if (nxt_ref_hi) begin
            sample = REF_HIGH_CODE;
        end else if (nxt_ref_lo) begin
            sample = REF_LOW_CODE;
        end else begin
            sample = analog_input_channels[7:0];  // R5
        end
    end

    // ------------------------------------------------------------
    // Routing registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            route_ff  <= '0;
            ref_hi_ff <= 1'b0;
            ref_lo_ff <= 1'b0;
            power_ff  <= 1'b0;
        end else begin
            route_ff  <= nxt_route;
            ref_hi_ff <= nxt_ref_hi;
            ref_lo_ff <= nxt_ref_lo;
            power_ff  <= nxt_power;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cycle = cycle_ff;
        done      = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_cycle = 5'h00;
            end
            ST_SYNC: begin
                // First tick aligns to the divider and counts as cycle 1 of the 16
                if (conv_tick) begin
                    nxt_state = ST_CONV;
                    nxt_cycle = 5'h01;
                end
            end
            ST_CONV: begin
                if (conv_tick) begin
                    if (cycle_ff >= CONV_CYCLES - 5'h01) begin  // R11
                        done      = 1'b1;
                        nxt_cycle = 5'h00;
                        nxt_state = continuous_ff ? ST_SYNC : ST_IDLE;
                    end else begin
                        nxt_cycle = cycle_ff + 5'h01;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cycle = 5'h00;
            end
        endcase
        if (wr_ctrl) begin
            nxt_state = ST_SYNC;  // R11
            nxt_cycle = 5'h00;
        end
        // The code being written decides, so leaving power-off starts at once
        if (stop_mode || nxt_channel == CHAN_POWER_OFF) begin
            nxt_state = ST_IDLE;  // R14 R15
            nxt_cycle = 5'h00;
            done      = 1'b0;
        end
        // Busy leaves its own flop so the pin follows the state cleanly
        nxt_busy = nxt_state != ST_IDLE;
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            cycle_ff <= 5'h00;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cycle_ff <= nxt_cycle;
            busy_ff  <= nxt_busy;
        end
    end

    // ------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------
    always_comb begin
        nxt_channel    = channel_select_field_ff;
        nxt_continuous = continuous_ff;
        nxt_irq_en     = irq_en_ff;
        nxt_prescale   = prescale_ff;
        nxt_source     = source_ff;
        nxt_result     = result_ff;
        nxt_complete   = complete_ff;
        nxt_first_done = first_done_ff;
        nxt_irq        = irq_ff;
        if (wr_ctrl) begin
            nxt_channel    = reg_wdata[CHAN_W-1:0];
            nxt_continuous = reg_wdata[BIT_CONTINUOUS];
            nxt_irq_en     = reg_wdata[BIT_IRQ_EN];
            nxt_complete   = 1'b0;  // R12
            nxt_first_done = 1'b0;
            nxt_irq        = 1'b0;  // R13
        end
        if (reg_wr && reg_addr == ADDR_CLOCK_SETUP) begin
            nxt_prescale = reg_wdata[PRESCALE_LSB +: 3];
            nxt_source   = reg_wdata[BIT_SOURCE];
        end
        if (rd_result) begin
            nxt_complete = 1'b0;  // R12
            nxt_irq      = 1'b0;  // R13
        end
        // Completion set wins over a same-cycle clear
        if (done) begin
            nxt_result = sample;  // R6 R12
            nxt_first_done = 1'b1;
            if (irq_en_ff) begin
                nxt_irq = 1'b1;  // R13
            end else if (!continuous_ff || !first_done_ff) begin
                nxt_complete = 1'b1;  // R12
            end
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS_CONTROL: nxt_rdata = {complete_ff, irq_en_ff, continuous_ff,
                                                  channel_select_field_ff};
                ADDR_RESULT:         nxt_rdata = result_ff;
                ADDR_CLOCK_SETUP:    nxt_rdata = {prescale_ff, source_ff, 4'h0};
                default:             nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            channel_select_field_ff <= CHAN_RESET;
            continuous_ff           <= 1'b0;
            irq_en_ff               <= 1'b0;
            complete_ff             <= 1'b0;
            first_done_ff           <= 1'b0;
            result_ff               <= 8'h00;
            prescale_ff             <= PRESCALE_RESET;
            source_ff               <= SOURCE_RESET;  // R9
            irq_ff                  <= 1'b0;
        end else begin
            channel_select_field_ff <= nxt_channel;
            continuous_ff           <= nxt_continuous;
            irq_en_ff               <= nxt_irq_en;
            complete_ff             <= nxt_complete;
            first_done_ff           <= nxt_first_done;
            result_ff               <= nxt_result;
            prescale_ff             <= nxt_prescale;
            source_ff               <= nxt_source;
            irq_ff                  <= nxt_irq;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata            = rdata_ff;
    assign channel_route        = route_ff;
    assign route_reference_high = ref_hi_ff;
    assign route_reference_low  = ref_lo_ff;
    assign converter_power_on   = power_ff;
    assign converter_busy       = busy_ff;
    assign conversion_irq       = irq_ff;

endmodule : conv_ctrl
`default_nettype wire

// [rtl/conv_ctrl_pkg.sv]
// Constants for the converter channel and clock control block.
// Assumes a plain register port with 3-bit word addresses.
package conv_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RESULT         = 3'h1;
    localparam logic [2:0] ADDR_CLOCK_SETUP    = 3'h2;

    // ------------------------------------------------------------
    // Status and control fields
    // ------------------------------------------------------------
    localparam int BIT_COMPLETE   = 7;
    localparam int BIT_IRQ_EN     = 6;
    localparam int BIT_CONTINUOUS = 5;
    localparam int CHAN_W         = 5;

    // ------------------------------------------------------------
    // Clock setup fields
    // ------------------------------------------------------------
    localparam int BIT_SOURCE     = 4;
    localparam int PRESCALE_LSB   = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] CHAN_RESET      = 5'h1F;
    localparam logic [2:0] PRESCALE_RESET  = 3'h0;
    localparam logic       SOURCE_RESET    = 1'b0;

    // ------------------------------------------------------------
    // Channel codes
    // ------------------------------------------------------------
    localparam logic [4:0] CHAN_LAST_EXT   = 5'h07;
    localparam logic [4:0] CHAN_REF_HIGH   = 5'h1D;
    localparam logic [4:0] CHAN_REF_LOW    = 5'h1E;
    localparam logic [4:0] CHAN_POWER_OFF  = 5'h1F;

    // ------------------------------------------------------------
    // Conversion timing, in converter clock cycles, and reference result codes
    // ------------------------------------------------------------
    localparam logic [4:0] CONV_CYCLES     = 5'h10;
    localparam logic [7:0] REF_HIGH_CODE   = 8'hFF;
    localparam logic [7:0] REF_LOW_CODE    = 8'h00;

endpackage : conv_ctrl_pkg

// [rtl/conv_clock_gen.sv]
// Converter clock enable generator: source select and prescaler.
// Assumes the oscillator reference is a level synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_gen
    import conv_ctrl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       source_sel,
    input  wire logic [2:0] prescale,
    input  wire logic       osc_ref,
    output logic            conv_tick
);
    logic       osc_d_ff;
    logic [3:0] div_ff;
    logic       tick_ff;
    logic       nxt_osc_d;
    logic [3:0] nxt_div;
    logic       nxt_tick;
    logic       src_edge;
    logic [3:0] limit;

    always_comb begin
        nxt_osc_d = osc_ref;
        // Bus clock gives an edge every cycle; oscillator on its rising edge
        src_edge  = source_sel ? 1'b1 : (osc_ref & ~osc_d_ff);  // R8
        case (prescale)  // R7
            3'b000:  limit = 4'h0;
            3'b001:  limit = 4'h1;
            3'b010:  limit = 4'h3;
            3'b011:  limit = 4'h7;
            default: limit = 4'hF;
        endcase
        nxt_div  = div_ff;
        nxt_tick = 1'b0;
        if (!run) begin
            nxt_div = 4'h0;
        end else if (src_edge) begin
            if (div_ff >= limit) begin
                nxt_div  = 4'h0;
                nxt_tick = 1'b1;
            end else begin
                nxt_div = div_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            osc_d_ff <= 1'b0;
            div_ff   <= 4'h0;
            tick_ff  <= 1'b0;
        end else begin
            osc_d_ff <= nxt_osc_d;
            div_ff   <= nxt_div;
            tick_ff  <= nxt_tick;
        end
    end

    assign conv_tick = tick_ff;
endmodule : conv_clock_gen
`default_nettype wire

// [tb/analog_source.sv]
// Model of the external analog input pins: one settled sample byte per channel.
// Assumes the bench steps the offset between conversions, or during a continuous run.
`timescale 1ns/1ps
`default_nettype none
module analog_source (
    input  wire logic [7:0]  offset,
    output logic      [63:0] chans
);
    // Channel n presents 11h * (n + 1) plus the offset
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            chans[i*8+:8] = 8'(8'h11 * (i + 1)) + offset;
        end
    end
endmodule : analog_source
`default_nettype wire

// [tb/conv_ctrl_properties.sv]
// Concurrent checks on the ports of the converter control block.
// Assumes a single clk_sys domain and the active-low rstn.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_properties
    import conv_ctrl_pkg::*;
#(
    parameter int NUM_CH = 8
)(
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic [2:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_rdata,
    input  wire logic                stop_mode,
    input  wire logic [NUM_CH-1:0]   channel_route,
    input  wire logic                route_reference_high,
    input  wire logic                route_reference_low,
    input  wire logic                converter_power_on,
    input  wire logic                converter_busy,
    input  wire logic                conversion_irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_route_one_hot: assert property ($onehot0({channel_route, route_reference_high,
        route_reference_low})) else $error("more than one input routed");
    chk_power_off_code: assert property (reg_wr && reg_addr == ADDR_STATUS_CONTROL
        && reg_wdata[4:0] == CHAN_POWER_OFF |-> ##2 !converter_power_on && !converter_busy)
        else $error("power-off code left converter running");
    chk_stop_power: assert property ($past(stop_mode) |-> !converter_power_on)
        else $error("converter powered in stop");
    chk_stop_abort: assert property (stop_mode |=> !converter_busy)
        else $error("conversion not aborted by stop");
    chk_busy_min: assert property ($rose(converter_busy) |-> (converter_busy
        || $past(stop_mode) || $past(reg_wr))[*8]) else $error("conversion ended early");
    chk_busy_ends: assert property ($rose(converter_busy) |-> ##[17:900] !converter_busy)
        else $error("conversion did not finish");
    chk_irq_read_clear: assert property (reg_rd && reg_addr == ADDR_RESULT
        && !converter_busy |=> !conversion_irq) else $error("irq not cleared by read");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
endmodule : conv_ctrl_properties
`default_nettype wire

bind conv_ctrl conv_ctrl_properties #(.NUM_CH(NUM_CH)) u_props (
    .clk_sys              (clk_sys),
    .rstn                 (rstn),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .stop_mode            (stop_mode),
    .channel_route        (channel_route),
    .route_reference_high (route_reference_high),
    .route_reference_low  (route_reference_low),
    .converter_power_on   (converter_power_on),
    .converter_busy       (converter_busy),
    .conversion_irq       (conversion_irq)
);

// [tb/tb.sv]
// Self-checking bench for the converter control block.
// Assumes the analog source model on the channel inputs.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import conv_ctrl_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        stop_mode = 1'b0;
    logic        osc = 1'b0;
    logic        osc_run = 1'b0;
    logic [7:0]  offset = 8'h00;
    logic [63:0] chans;
    logic [7:0]  reg_rdata;
    logic [7:0]  v;
    logic [7:0]  route;
    logic        ref_hi;
    logic        ref_lo;
    logic        pwr;
    logic        busy;
    logic        irq;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          n;
    // Channel code, expected result, expected {high, low, route}
    logic [22:0] rows [10] = '{{5'h00, 8'h11, 10'h001}, {5'h01, 8'h22, 10'h002},
        {5'h02, 8'h33, 10'h004}, {5'h03, 8'h44, 10'h008}, {5'h04, 8'h55, 10'h010},
        {5'h05, 8'h66, 10'h020}, {5'h06, 8'h77, 10'h040}, {5'h07, 8'h88, 10'h080},
        {5'h1D, 8'hFF, 10'h200}, {5'h1E, 8'h00, 10'h100}};
    logic [2:0]  pc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int          dv [6] = '{1, 2, 4, 8, 16, 16};

    always #10 clk_sys = ~clk_sys;
    always #40 if (osc_run) osc = ~osc;

    analog_source u_src (.offset(offset), .chans(chans));
    conv_ctrl #(.NUM_CH(8)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .stop_mode(stop_mode), .oscillator_reference_clock(osc),
        .analog_input_channels(chans), .channel_route(route),
        .route_reference_high(ref_hi), .route_reference_low(ref_lo),
        .converter_power_on(pwr), .converter_busy(busy), .conversion_irq(irq));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic wait_idle(output int c);
        c = 0;
        while (busy === 1'b1 && c < 2000) begin
            @(posedge clk_sys);
            #1;
            c++;
        end
    endtask : wait_idle

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(ADDR_CLOCK_SETUP, v);
        check("clock_setup", 16'(v), 16'h0000);
        rd(ADDR_STATUS_CONTROL, v);
        check("status", 16'(v), 16'(CHAN_RESET));
        rd(3'h5, v);
        check("unmapped", 16'(v), 16'h0000);
        check("power_on", 16'(pwr), 16'h0000);
        $display("test reset done");
        wr(ADDR_CLOCK_SETUP, 8'h10);
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_STATUS_CONTROL, {3'h0, rows[i][22:18]});
            wait_idle(n);
            check("route", 16'({ref_hi, ref_lo, route}), 16'(rows[i][9:0]));
            rd(ADDR_STATUS_CONTROL, v);
            check("status", 16'(v), 16'({3'h4, rows[i][22:18]}));
            rd(ADDR_RESULT, v);
            check("result", 16'(v), 16'(rows[i][17:10]));
        end
        $display("test channels done");
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CLOCK_SETUP, {pc[i], 5'h10});
            rd(ADDR_CLOCK_SETUP, v);
            check("clock_setup", 16'(v), 16'({pc[i], 5'h10}));
            wr(ADDR_STATUS_CONTROL, 8'h03);
            wait_idle(n);
            check("div_cycles", 16'(n >= 16 * dv[i] && n <= 17 * dv[i] + 1), 16'h0001);
        end
        $display("test prescaler done");
        wr(ADDR_CLOCK_SETUP, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h02);
        repeat (100) @(posedge clk_sys);
        check("busy_osc_still", 16'(busy), 16'h0001);
        osc_run = 1'b1;
        wait_idle(n);
        osc_run = 1'b0;
        rd(ADDR_RESULT, v);
        check("result_osc", 16'(v), 16'h0033);
        $display("test oscillator done");
        wr(ADDR_CLOCK_SETUP, 8'h10);
        wr(ADDR_STATUS_CONTROL, 8'h5F);
        repeat (20) @(posedge clk_sys);
        check("off_state", 16'({pwr, busy, irq}), 16'h0000);
        wr(ADDR_STATUS_CONTROL, 8'h04);
        repeat (5) @(posedge clk_sys);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check("stop_state", 16'({pwr, busy}), 16'h0000);
        stop_mode <= 1'b0;
        wr(ADDR_STATUS_CONTROL, 8'h04);
        wait_idle(n);
        wr(ADDR_STATUS_CONTROL, 8'h04);
        wait_idle(n);
        rd(ADDR_RESULT, v);
        check("result_resume", 16'(v), 16'h0055);
        $display("test power and stop done");
        wr(ADDR_STATUS_CONTROL, 8'h42);
        wait_idle(n);
        check("irq_set", 16'(irq), 16'h0001);
        rd(ADDR_STATUS_CONTROL, v);
        check("status_irq", 16'(v), 16'h0042);
        rd(ADDR_RESULT, v);
        check("irq_read_clear", 16'(irq), 16'h0000);
        wr(ADDR_STATUS_CONTROL, 8'h42);
        wait_idle(n);
        wr(ADDR_STATUS_CONTROL, 8'h02);
        check("irq_write_clear", 16'(irq), 16'h0000);
        wait_idle(n);
        $display("test interrupt done");
        wr(ADDR_STATUS_CONTROL, 8'h21);
        repeat (60) @(posedge clk_sys);
        rd(ADDR_STATUS_CONTROL, v);
        check("status_cont", 16'(v), 16'h00A1);
        offset <= 8'h01;
        repeat (60) @(posedge clk_sys);
        rd(ADDR_RESULT, v);
        check("result_overwrite", 16'(v), 16'h0023);
        wr(ADDR_STATUS_CONTROL, 8'h1F);
        $display("test continuous done");
        test_done();
    end
endmodule : tb
`default_nettype wire
